// >>> rbr_pkg.sv
// Shared constants and types for the recirculation burst read control
package rbr_pkg;
  localparam int          ADDR_W_DEF     = 10;
  localparam int          SAMP_W_DEF     = 8;
  localparam int          BLK_W          = 8;
  localparam int          LEN_W          = 16;
  localparam int          TS_W           = 32;
  localparam int          BB_W           = 2;
  localparam int          MAX_WIDE_BB    = 2;
  localparam logic [1:0]  CLR_CYCLES     = 2'h2;
  localparam logic [15:0] BURST_LEN_DEF  = 16'h0200;
  typedef enum logic [1:0] {
    RBR_MODE_NORMAL,
    RBR_MODE_WIDE,
    RBR_MODE_DELAY
  } rbr_mode_e;
  typedef enum logic [1:0] {
    RBR_IDLE,
    RBR_CLEAR,
    RBR_BURST,
    RBR_HOLD
  } rbr_state_e;
endpackage

// >>> rbr_mem.sv
// Circular sample memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rbr_mem #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 8
) (
  // Clock
  input  wire logic              clk,
  input  wire logic              ce,
  // Write side
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read side
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// >>> rbr_ctrl.sv
// Recirculation burst read control: buffer pointers, bursts, dump records
//
// How it works
// - Read pointer advances, per burst, only as far as credit earned by writes allows.
// - Burst dump records carry the burst timestamp unchanged; a delay-mode record carries in_time at the dump.
// - Configured burst length can be shortened, shortening dump period.
// - Normal bursts read only with credit earned by writes, so reads follow input rate.
// - Wide mode recirculates at full write rate, time-multiplexing lag blocks.
// - Wide-band recirculation accepted only on basebands zero and one.
// - Delay mode keeps the block number fixed at its configured start.
// - Delay mode reads continuously, one read per write.
// - Delay mode never raises lag-chain clear at a dump.
// - Lag chain emptied before each burst in recirculation modes.
// - Zero-delay pointer half a buffer back; start pointer older by block number times block delay.
`timescale 1ns/1ps
`default_nettype none
module rbr_ctrl
  import rbr_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int SAMP_W = SAMP_W_DEF
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // Configuration
  input  wire rbr_pkg::rbr_mode_e mode,
  input  wire logic [rbr_pkg::BB_W-1:0]  baseband,
  input  wire logic [rbr_pkg::BLK_W-1:0] start_block,
  input  wire logic [rbr_pkg::BLK_W-1:0] num_blocks,
  input  wire logic [ADDR_W-1:0]         block_delay,
  input  wire logic [rbr_pkg::LEN_W-1:0] burst_len,
  // Sample input
  input  wire logic               in_valid,
  input  wire logic [SAMP_W-1:0]  in_data,
  input  wire logic [rbr_pkg::TS_W-1:0]  in_time,
  // Dump command
  input  wire logic               dump,
  // Correlator output stream
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic      [SAMP_W-1:0]  out_data,
  output logic                    lag_chain_clear,
  // Dump record to the long_term_accumulator controller
  output logic                    rec_valid,
  output logic [rbr_pkg::BLK_W-1:0] rec_block,
  output logic [rbr_pkg::TS_W-1:0]  rec_time,
  output logic                    rec_last,
  // Status
  output logic                    cfg_error
);
  import rbr_pkg::*;

  localparam logic [ADDR_W-1:0] HALF_BUF = ADDR_W'(1) << (ADDR_W - 1);

  function automatic logic [ADDR_W-1:0] ptr_inc(input logic [ADDR_W-1:0] p);
    return p + ADDR_W'(1);
  endfunction

  rbr_state_e        st_r, st_nxt;
  logic [ADDR_W-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [ADDR_W-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [ADDR_W-1:0] zero_delay_read_ptr;
  logic [ADDR_W-1:0] start_read_ptr;
  logic [LEN_W-1:0]  cnt_r, cnt_nxt;
  logic [LEN_W-1:0]  credit_r, credit_nxt;
  logic [1:0]        clr_r, clr_nxt;
  logic [BLK_W-1:0]  blk_r, blk_nxt;
  logic [TS_W-1:0]   mean_burst_time_r, mean_burst_time_nxt;
  logic              rec_v_r, rec_v_nxt;
  logic [BLK_W-1:0]  rec_b_r, rec_b_nxt;
  logic [TS_W-1:0]   rec_t_r, rec_t_nxt;
  logic              rec_l_r, rec_l_nxt;
  logic              rd_go, mem_v_r;
  logic [SAMP_W-1:0] mem_q;
  logic              buf_ready;
  logic              wide_ok;
  logic              burst_mode;

  // Only two basebands have memory width for full-rate recirculation
  assign wide_ok    = baseband < BB_W'(MAX_WIDE_BB);
  assign cfg_error  = (mode == RBR_MODE_WIDE) && !wide_ok;
  assign burst_mode = (mode != RBR_MODE_DELAY);

  assign zero_delay_read_ptr = wr_ptr_r - HALF_BUF;
  // Offset by the block of the burst about to begin, not the one ending
  assign start_read_ptr = zero_delay_read_ptr - ADDR_W'(blk_nxt * block_delay);

  // Read gating: burst may read only with earned credit, so on average the
  // read pointer never outruns the write pointer
  always_comb begin
    rd_go = 1'b0;
    case (st_r)
      RBR_BURST: rd_go = buf_ready && (credit_r != '0);
      RBR_HOLD:  rd_go = buf_ready && in_valid;
      default:   rd_go = 1'b0;
    endcase
  end

  // Pointer group
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    credit_nxt = credit_r;
    if (in_valid) begin
      wr_ptr_nxt = ptr_inc(wr_ptr_r);
    end
    if (rd_go) begin
      rd_ptr_nxt = ptr_inc(rd_ptr_r);
    end
    // credit counts writes not yet matched by a read
    if (in_valid && !rd_go && credit_r != '1) begin
      credit_nxt = credit_r + LEN_W'(1);
    end else if (rd_go && !in_valid && st_r == RBR_BURST) begin
      credit_nxt = credit_r - LEN_W'(1);
    end
    if (dump && st_r != RBR_HOLD && !(mode == RBR_MODE_DELAY)) begin
      rd_ptr_nxt = start_read_ptr;
    end else if (st_r == RBR_IDLE && mode == RBR_MODE_DELAY) begin
      rd_ptr_nxt = start_read_ptr;
      credit_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      credit_r <= '0;
    end else if (ce) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      credit_r <= credit_nxt;
    end
  end

  // Burst sequencing group
  always_comb begin
    st_nxt              = st_r;
    cnt_nxt             = cnt_r;
    clr_nxt             = clr_r;
    blk_nxt             = blk_r;
    mean_burst_time_nxt = mean_burst_time_r;
    rec_v_nxt           = 1'b0;
    rec_b_nxt           = rec_b_r;
    rec_t_nxt           = rec_t_r;
    rec_l_nxt           = rec_l_r;
    case (st_r)
      RBR_IDLE: begin
        blk_nxt = start_block;
        if (mode == RBR_MODE_DELAY) begin
          st_nxt = RBR_HOLD;
        end else if (dump && !cfg_error) begin
          st_nxt  = RBR_CLEAR;
          clr_nxt = CLR_CYCLES;
          mean_burst_time_nxt = in_time;
        end
      end
      RBR_CLEAR: begin
        if (cfg_error) begin
          st_nxt = RBR_IDLE;
        end else if (clr_r <= 2'h1) begin
          st_nxt  = RBR_BURST;
          cnt_nxt = (burst_len == '0) ? BURST_LEN_DEF : burst_len;
        end
        clr_nxt = clr_r - 2'h1;
      end
      RBR_BURST: begin
        if (rd_go) begin
          cnt_nxt = cnt_r - LEN_W'(1);
        end
        if (dump || (rd_go && cnt_r == LEN_W'(1))) begin
          rec_v_nxt = 1'b1;
          rec_b_nxt = blk_r;
          rec_t_nxt = mean_burst_time_r;
          rec_l_nxt = (blk_r + BLK_W'(1) >= start_block + num_blocks);
          blk_nxt   = rec_l_nxt ? start_block : blk_r + BLK_W'(1);
          mean_burst_time_nxt = in_time;
          st_nxt  = burst_mode ? RBR_CLEAR : RBR_IDLE;
          clr_nxt = CLR_CYCLES;
        end else if (cfg_error) begin
          st_nxt = RBR_IDLE;
        end
      end
      RBR_HOLD: begin
        blk_nxt = start_block;
        if (dump) begin
          rec_v_nxt = 1'b1;
          rec_b_nxt = start_block;
          rec_t_nxt = in_time;
          rec_l_nxt = 1'b1;
        end
        if (mode != RBR_MODE_DELAY) begin
          st_nxt = RBR_IDLE;
        end
      end
      default: st_nxt = RBR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r              <= RBR_IDLE;
      cnt_r             <= '0;
      clr_r             <= '0;
      blk_r             <= '0;
      mean_burst_time_r <= '0;
      rec_v_r           <= 1'b0;
      rec_b_r           <= '0;
      rec_t_r           <= '0;
      rec_l_r           <= 1'b0;
    end else if (ce) begin
      st_r              <= st_nxt;
      cnt_r             <= cnt_nxt;
      clr_r             <= clr_nxt;
      blk_r             <= blk_nxt;
      mean_burst_time_r <= mean_burst_time_nxt;
      rec_v_r           <= rec_v_nxt;
      rec_b_r           <= rec_b_nxt;
      rec_t_r           <= rec_t_nxt;
      rec_l_r           <= rec_l_nxt;
    end
  end

  // Clear only in burst modes, while no memory read is issued
  assign lag_chain_clear = (st_r == RBR_CLEAR);
  assign rec_valid = rec_v_r;
  assign rec_block = rec_b_r;
  assign rec_time  = rec_t_r;
  assign rec_last  = rec_l_r;

  rbr_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (SAMP_W)
  ) u_mem (
    .clk     (clk),
    .ce      (ce),
    .wr_en   (in_valid),
    .wr_addr (wr_ptr_r),
    .wr_data (in_data),
    .rd_en   (rd_go),
    .rd_addr (rd_ptr_r),
    .rd_data (mem_q)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_v_r <= 1'b0;
    end else if (ce) begin
      mem_v_r <= rd_go;
    end
  end

  // Two-entry skid buffer between memory and correlator
  logic [SAMP_W-1:0] b0_r, b1_r, b0_nxt, b1_nxt;
  logic [1:0]        n_r, n_nxt;
  logic              pop;
  assign pop       = out_valid && out_ready;
  assign out_valid = (n_r != 2'h0);
  assign out_data  = b0_r;
  // Room for one more word with a read already in flight
  // A pop with a word landing keeps one read per cycle at full rate
  assign buf_ready = (n_r == 2'h0) || (n_r == 2'h1 && (pop || !mem_v_r))
                     || (n_r == 2'h2 && pop && !mem_v_r);

  always_comb begin
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    n_nxt  = n_r;
    if (pop) begin
      b0_nxt = b1_r;
      n_nxt  = n_r - 2'h1;
    end
    if (mem_v_r) begin
      if (n_nxt == 2'h0) begin
        b0_nxt = mem_q;
      end else begin
        b1_nxt = mem_q;
      end
      n_nxt = n_nxt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b0_r <= '0;
      b1_r <= '0;
      n_r  <= 2'h0;
    end else if (ce) begin
      b0_r <= b0_nxt;
      b1_r <= b1_nxt;
      n_r  <= n_nxt;
    end
  end

  // Checks
  property p_delay_no_clear;
    @(posedge clk) disable iff (!rstn)
    (st_r == RBR_HOLD) |-> !lag_chain_clear;
  endproperty
  a_delay_no_clear: assert property (p_delay_no_clear)
    else $error("lag chain clear raised in delay mode");

  property p_clear_before_burst;
    @(posedge clk) disable iff (!rstn)
    (ce && st_r != RBR_BURST && st_nxt == RBR_BURST) |-> lag_chain_clear;
  endproperty
  a_clear_before_burst: assert property (p_clear_before_burst)
    else $error("burst started without clear");

  property p_dump_clears;
    @(posedge clk) disable iff (!rstn)
    (ce && st_r == RBR_BURST && dump && burst_mode) |=> lag_chain_clear;
  endproperty
  a_dump_clears: assert property (p_dump_clears)
    else $error("no clear after burst dump");

  property p_block_const;
    @(posedge clk) disable iff (!rstn)
    (st_r == RBR_HOLD && $past(st_r) == RBR_HOLD) |-> blk_r == start_block;
  endproperty
  a_block_const: assert property (p_block_const)
    else $error("block number moved in delay mode");

  property p_equal_rate;
    @(posedge clk) disable iff (!rstn)
    (st_r == RBR_HOLD && buf_ready && ce) |-> (rd_go == in_valid);
  endproperty
  a_equal_rate: assert property (p_equal_rate)
    else $error("delay mode read rate differs from write rate");

  property p_credit;
    @(posedge clk) disable iff (!rstn)
    (st_r == RBR_BURST && credit_r == '0) |-> !rd_go;
  endproperty
  a_credit: assert property (p_credit)
    else $error("read overtook write");

  property p_ts;
    @(posedge clk) disable iff (!rstn)
    (ce && st_r == RBR_BURST && rec_v_nxt) |=> rec_time == $past(mean_burst_time_r);
  endproperty
  a_ts: assert property (p_ts)
    else $error("dump record timestamp altered");

  property p_wide;
    @(posedge clk) disable iff (!rstn)
    cfg_error |-> st_r != RBR_BURST || $past(st_r) == RBR_BURST;
  endproperty
  a_wide: assert property (p_wide)
    else $error("wide burst started on disallowed baseband");

  property p_zd;
    @(posedge clk) disable iff (!rstn)
    (wr_ptr_r - zero_delay_read_ptr) == HALF_BUF;
  endproperty
  a_zd: assert property (p_zd)
    else $error("zero delay pointer misplaced");
endmodule
`default_nettype wire

// >>> rbr_sink.sv
// Far-side model: correlator stream input and accumulator record sink
`timescale 1ns/1ps
`default_nettype none
module rbr_sink (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Pace control
  input  wire logic stall,
  // Stream and records
  input  wire logic out_valid,
  output logic      out_ready,
  input  wire logic rec_valid,
  // Counts
  output var int    n_words,
  output var int    n_recs
);
  logic [1:0] ph_r;
  // A slow partner takes one word in four
  assign out_ready = !stall || (ph_r == 2'h3);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_r <= 2'h0;
      n_words <= 0;
      n_recs <= 0;
    end else begin
      ph_r <= ph_r + 2'h1;
      if (out_valid && out_ready) begin
        n_words <= n_words + 1;
      end
      if (rec_valid) begin
        n_recs <= n_recs + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test_recirculation_burst_read_control.sv
// Testbench for the recirculation burst read control
`timescale 1ns/1ps
`default_nettype none
module test_recirculation_burst_read_control;
  import rbr_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  rbr_mode_e   mode = RBR_MODE_NORMAL;
  logic [1:0]  baseband = 2'h0;
  logic [7:0]  start_block = 8'h00;
  logic [7:0]  num_blocks = 8'h04;
  logic [9:0]  block_delay = 10'h004;
  logic [15:0] burst_len = 16'h0004;
  logic        in_valid = 1'b0;
  logic [7:0]  in_data = 8'h00;
  logic [31:0] in_time = 32'h0;
  logic        dump = 1'b0;
  logic        stall = 1'b0;
  logic        out_valid, out_ready, lag_chain_clear, rec_valid, rec_last;
  logic        cfg_error;
  logic [7:0]  out_data, rec_block;
  logic [31:0] rec_time;
  int          n_words, n_recs, mismatches = 0, tests_run = 0;

  always #2.5 clk = ~clk;

  rbr_ctrl u_dut (.clk(clk), .rstn(rstn), .ce(1'b1), .mode(mode),
    .baseband(baseband), .start_block(start_block),
    .num_blocks(num_blocks), .block_delay(block_delay),
    .burst_len(burst_len), .in_valid(in_valid), .in_data(in_data),
    .in_time(in_time), .dump(dump), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data),
    .lag_chain_clear(lag_chain_clear), .rec_valid(rec_valid),
    .rec_block(rec_block), .rec_time(rec_time), .rec_last(rec_last),
    .cfg_error(cfg_error));

  rbr_sink u_sink (.clk(clk), .rstn(rstn), .stall(stall),
    .out_valid(out_valid), .out_ready(out_ready), .rec_valid(rec_valid),
    .n_words(n_words), .n_recs(n_recs));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: value %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // Pulses dump, then counts clear cycles over the following four
  task automatic dump_clr(output int clr);
    dump = 1'b1;
    cyc(1);
    dump = 1'b0;
    clr = 0;
    repeat (4) begin
      if (lag_chain_clear === 1'b1) clr++;
      cyc(1);
    end
  endtask

  // One write per (gap+1) cycles
  task automatic feed(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      in_valid = 1'b1;
      in_data = in_data + 8'h01;
      cyc(1);
      if (gap > 0) begin
        in_valid = 1'b0;
        cyc(gap);
      end
    end
    if (gap == 0) in_valid = 1'b0;
  endtask

  task automatic wait_rec(input int target);
    for (int i = 0; i < 300 && n_recs < target; i++) cyc(1);
  endtask

  task automatic t_reset();
    chk_bit(out_valid, 1'b0);
    chk_bit(rec_valid, 1'b0);
    chk_bit(lag_chain_clear, 1'b0);
    chk_bit(cfg_error, 1'b0);
    $display("test reset done");
  endtask

  // Recirculation burst: clear first, reads gated by writes, short length
  task automatic t_burst(input rbr_mode_e md, input logic [1:0] bb,
                         input int gap, input logic stl,
                         input logic [31:0] ts);
    int w0, r0, clr;
    mode = md;
    baseband = bb;
    stall = stl;
    in_time = ts;
    cyc(3);
    chk_bit(cfg_error, 1'b0);
    w0 = n_words;
    dump_clr(clr);
    chk_num(clr, 2);
    chk_num(n_words - w0, 0);
    // A dump that cuts a running burst has already sent its record
    r0 = n_recs;
    cyc(6);
    chk_num(n_words - w0, 0);
    // Eight writes fill exactly two bursts of the short length
    feed(8, gap);
    wait_rec(r0 + 2);
    cyc(20);
    chk_num(n_words - w0, 8);
    chk_num(n_recs - r0, 2);
    chk_num(rec_time, ts);
    stall = 1'b0;
    $display("test burst mode %0d done", md);
  endtask

  task automatic t_badband();
    int r0, clr;
    mode = RBR_MODE_WIDE;
    baseband = 2'h2;
    cyc(2);
    chk_bit(cfg_error, 1'b1);
    r0 = n_recs;
    dump_clr(clr);
    chk_num(clr, 0);
    cyc(20);
    chk_num(n_recs - r0, 0);
    baseband = 2'h0;
    $display("test wide band limit done");
  endtask

  task automatic t_delay();
    int w0, r0, clr;
    mode = RBR_MODE_DELAY;
    start_block = 8'h05;
    // Half buffer plus five blocks of 104 leaves the read eight samples back
    block_delay = 10'h068;
    in_time = 32'h0000_7a31;
    cyc(4);
    for (int k = 0; k < 2; k++) begin
      w0 = n_words;
      r0 = n_recs;
      dump_clr(clr);
      chk_num(clr, 0);
      chk_num(n_recs - r0, 1);
      chk_num(rec_block, 8'h05);
      chk_bit(rec_last, 1'b1);
      feed(6, 0);
      cyc(10);
      chk_num(n_words - w0, 6);
    end
    feed(1, 0);
    for (int i = 0; i < 8 && out_valid !== 1'b1; i++) cyc(1);
    chk_num(out_data, 8'(in_data - 8'h08));
    $display("test delay mode done");
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    cyc(12);
    rstn = 1'b1;
    t_reset();
    t_burst(RBR_MODE_NORMAL, 2'h0, 1, 1'b1, 32'h0000_1234);
    t_burst(RBR_MODE_WIDE, 2'h1, 0, 1'b0, 32'h0000_5678);
    t_badband();
    t_delay();
    summarize();
  end

  // Whole run is a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
